/* verilog/acs_pkg.sv */
package acs_pkg;
  // ****************************************
  // Address and codes
  // ****************************************
  localparam logic [6:0] DEV_ADDR       = 7'h2A;  // Arbitrary value
  localparam logic [4:0] HS_CODE_TOP    = 5'h01;  // Master code 0000_1xxx
  // ****************************************
  // Byte field positions
  // ****************************************
  localparam int         REG_SEL_BIT    = 7;
  localparam int         REFERENCE_CHOICE_BIT2_BIT       = 6;
  localparam int         REFERENCE_CHOICE_BIT1_BIT       = 5;
  localparam int         REFERENCE_CHOICE_BIT0_BIT       = 4;
  localparam int         CLK_SRC_BIT    = 3;
  localparam int         POL_BIT        = 2;
  localparam int         RST_N_BIT      = 1;
  localparam int         PAIR_BIT       = 0;
  localparam int         CHAN_LSB       = 1;
  localparam int         SCAN_LSB       = 5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SETUP_RESET    = 8'h82;
  localparam logic [7:0] CONFIG_RESET   = 8'h01;
  // ****************************************
  // Link timing
  // ****************************************
  localparam int         CLK_HZ         = 50000000;
  localparam int         SCL_HALF_NS    = 1000;
  localparam int         SCL_HALF_CYC   = (SCL_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // ****************************************
  // Master register map (AHB-Lite)
  // ****************************************
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_DATA       = 8'h04;
  localparam logic [7:0] OFF_STAT       = 8'h08;
  localparam int         CTRL_START     = 0;
  localparam int         CTRL_STOP      = 1;
  localparam int         CTRL_WRITE     = 2;
  localparam int         CTRL_READ      = 3;
  localparam int         CTRL_ACKOUT    = 4;
  localparam int         STAT_BUSY      = 0;
  localparam int         STAT_NACK      = 1;
endpackage

/* verilog/acs_link_if.sv */
`timescale 1ns/1ps
// Two-wire link: open-drain levels resolved here
interface acs_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Pull-ups win unless some end drives low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe,
                  output sda_m_o, output sda_m_oe);
endinterface

/* verilog/acs_slave.sv */
// Design decisions made here: register writes over the two-wire link, sampled on hclk, and the placing of the registers.
`timescale 1ns/1ps
module acs_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  acs_link_if.device       link,
  output logic [7:0]       setup_byte,
  output logic [7:0]       config_byte,
  output logic             hs_mode,
  output logic             ext_clock,
  output logic [2:0]       ref_select,
  output logic             single_ended,
  output logic             bipolar,
  output logic [3:0]       chan_sel,
  output logic [1:0]       scan_sel,
  output logic             read_req,
  input  wire logic [8:0]  diff_code,
  output logic [7:0]       out_code
);
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_ADDR = 2'b01,
    ACS_DATA = 2'b11,
    ACS_SKIP = 2'b10
  } acs_state_t;

  // ****************************************
  // Input synchronisers and edge detect
  // ****************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign start_ev = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_ev  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // ****************************************
  // Byte engine
  // ****************************************
  acs_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic       ack_phase;
  logic       hs_pending;
  logic       byte_done;
  assign byte_done = scl_rise && bit_cnt == 4'd7 && !ack_phase;

  // Bit counting: eight data bits then acknowledge slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt   <= 4'd0;
      shreg     <= 8'h00;
      ack_phase <= 1'b0;
    end else if (start_ev || stop_ev) begin
      bit_cnt   <= 4'd0;
      ack_phase <= 1'b0;
    end else if (scl_rise && !ack_phase) begin
      shreg   <= {shreg[6:0], sda_sync[1]};
      bit_cnt <= bit_cnt + 4'd1;
    end else if (scl_fall && bit_cnt == 4'd8) begin
      bit_cnt   <= 4'd0;
      ack_phase <= 1'b1;
    end else if (scl_fall && ack_phase) begin
      ack_phase <= 1'b0;
    end
  end

  // Received byte, MSB first, completed at eighth rise
  logic [7:0] rx_byte;
  assign rx_byte = {shreg[6:0], sda_sync[1]};

  // Protocol state and acknowledge decision
  logic ack_now;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= ACS_IDLE;
      ack_now  <= 1'b0;
      read_req <= 1'b0;
    end else if (stop_ev) begin
      state   <= ACS_IDLE;
      ack_now <= 1'b0;
    end else if (start_ev) begin
      state   <= ACS_ADDR;
      ack_now <= 1'b0;
    end else if (byte_done) begin
      unique case (state)
        ACS_ADDR: begin
          if (rx_byte[7:1] == acs_pkg::DEV_ADDR) begin
            ack_now  <= 1'b1;
            read_req <= rx_byte[0];
            state    <= rx_byte[0] ? ACS_SKIP : ACS_DATA;
          end else begin
            ack_now <= 1'b0;
            state   <= ACS_SKIP;
          end
        end
        ACS_DATA: ack_now <= 1'b1;
        ACS_SKIP: ack_now <= 1'b0;
        ACS_IDLE: ack_now <= 1'b0;
      endcase
    end else if (scl_fall && ack_phase) begin
      ack_now <= 1'b0;
    end
  end

  // Drive SDA low only during acknowledge slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.sda_s_o  <= 1'b1;
      link.sda_s_oe <= 1'b0;
    end else begin
      link.sda_s_o  <= 1'b0;
      link.sda_s_oe <= ack_now && ack_phase;
    end
  end

  // ****************************************
  // Timing mode
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_mode    <= 1'b0;
      hs_pending <= 1'b0;
    end else if (stop_ev) begin
      hs_mode    <= 1'b0;
      hs_pending <= 1'b0;
    end else if (byte_done && state == ACS_ADDR &&
                 rx_byte[7:3] == acs_pkg::HS_CODE_TOP) begin
      hs_pending <= 1'b1;
    end else if (hs_pending && scl_fall && ack_phase) begin
      hs_mode    <= 1'b1;
      hs_pending <= 1'b0;
    end
  end

  // ****************************************
  // Setup and configuration bytes
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_byte  <= acs_pkg::SETUP_RESET;
      config_byte <= acs_pkg::CONFIG_RESET;
    end else if (byte_done && state == ACS_DATA) begin
      if (rx_byte[acs_pkg::REG_SEL_BIT]) begin
        setup_byte <= {rx_byte[7:1], 1'b0};
        if (!rx_byte[acs_pkg::RST_N_BIT]) begin
          config_byte <= acs_pkg::CONFIG_RESET;
        end
      end else begin
        config_byte <= rx_byte;
      end
    end
  end

  // ****************************************
  // Decoded controls and output coding
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_clock    <= 1'b0;
      ref_select   <= 3'b000;
      single_ended <= 1'b1;
      bipolar      <= 1'b0;
      chan_sel     <= 4'h0;
      scan_sel     <= 2'b00;
      out_code     <= 8'h00;
    end else begin
      ext_clock    <= setup_byte[acs_pkg::CLK_SRC_BIT];
      ref_select   <= setup_byte[acs_pkg::REFERENCE_CHOICE_BIT2_BIT:acs_pkg::REFERENCE_CHOICE_BIT0_BIT];
      single_ended <= config_byte[acs_pkg::PAIR_BIT];
      chan_sel     <= config_byte[acs_pkg::CHAN_LSB +: 4];
      scan_sel     <= config_byte[acs_pkg::SCAN_LSB +: 2];
      // Polarity only in paired mode
      bipolar <= setup_byte[acs_pkg::POL_BIT] &
                 ~config_byte[acs_pkg::PAIR_BIT];
      if (bipolar) begin
        out_code <= diff_code[8:1];
      end else if (diff_code[8]) begin
        out_code <= 8'h00;
      end else begin
        out_code <= diff_code[7:0];
      end
    end
  end
endmodule // acs_slave

/* verilog/acs_master.sv */
`timescale 1ns/1ps
// AHB-Lite driven bus master for the two-wire link
module acs_master (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  acs_link_if.master       link
);
  typedef enum logic [2:0] {
    ACM_IDLE = 3'b000, ACM_LOW = 3'b001, ACM_HIGH = 3'b011, ACM_DONE = 3'b010
  } acm_state_t;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       go;
  logic [4:0] cmd;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic       busy;
  logic       nack;
  logic       sda_in;
  logic [1:0] sda_sync;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        unique case (haddr[7:0])
          acs_pkg::OFF_DATA: hrdata <= {24'h000000, rx_byte};
          acs_pkg::OFF_STAT: hrdata <= {30'h0, nack, busy};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Register writes: command launch and transmit byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go      <= 1'b0;
      cmd     <= 5'h00;
      tx_byte <= 8'h00;
    end else begin
      go <= 1'b0;
      if (wr_pend && wr_addr == acs_pkg::OFF_DATA) tx_byte <= hwdata[7:0];
      if (wr_pend && wr_addr == acs_pkg::OFF_CTRL && !busy) begin
        cmd <= hwdata[4:0];
        go  <= 1'b1;
      end
    end
  end

  // ****************************************
  // Bit engine: start, 9 bits, stop
  // ****************************************
  acm_state_t state;
  logic [7:0] tick;
  logic [3:0] bitn;
  logic [8:0] sh;
  logic [1:0] phase; // 0 start,1 byte,2 stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_sync <= 2'b11;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end
  assign sda_in = sda_sync[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= ACM_IDLE;
      tick          <= 8'h00;
      bitn          <= 4'h0;
      sh            <= 9'h1FF;
      phase         <= 2'd0;
      busy          <= 1'b0;
      nack          <= 1'b0;
      rx_byte       <= 8'h00;
      link.scl_o    <= 1'b1;
      link.scl_oe   <= 1'b0;
      link.sda_m_o  <= 1'b1;
      link.sda_m_oe <= 1'b0;
    end else begin
      link.scl_o   <= 1'b0;
      link.sda_m_o <= 1'b0;
      unique case (state)
        ACM_IDLE: begin
          if (go) begin
            busy  <= 1'b1;
            tick  <= 8'h00;
            bitn  <= 4'h0;
            sh    <= cmd[acs_pkg::CTRL_READ] ? {8'hFF, ~cmd[acs_pkg::CTRL_ACKOUT]}
                                              : {tx_byte, 1'b1};
            phase <= cmd[acs_pkg::CTRL_START] ? 2'd0 :
                     (cmd[acs_pkg::CTRL_WRITE] | cmd[acs_pkg::CTRL_READ]) ? 2'd1 : 2'd2;
            state <= ACM_LOW;
          end
        end
        ACM_LOW: begin
          // SCL low: set SDA for the coming high phase
          link.scl_oe <= 1'b1;
          link.sda_m_oe <= (phase == 2'd1) ? ~sh[8] : (phase == 2'd2);
          if (phase == 2'd0) link.sda_m_oe <= 1'b0;
          tick <= tick + 8'h01;
          if (tick == 8'(acs_pkg::SCL_HALF_CYC)) begin
            tick  <= 8'h00;
            state <= ACM_HIGH;
          end
        end
        ACM_HIGH: begin
          link.scl_oe <= 1'b0;
          tick <= tick + 8'h01;
          if (tick == 8'(acs_pkg::SCL_HALF_CYC)) begin
            if (phase == 2'd0) link.sda_m_oe <= 1'b1; // Start
            if (phase == 2'd2) link.sda_m_oe <= 1'b0; // Stop
          end
          if (tick == 8'(2 * acs_pkg::SCL_HALF_CYC)) begin
            tick <= 8'h00;
            if (phase == 2'd1) begin
              sh   <= {sh[7:0], 1'b1};
              bitn <= bitn + 4'h1;
              if (bitn < 4'd8) rx_byte <= {rx_byte[6:0], sda_in};
              if (bitn == 4'd8) begin
                nack  <= sda_in;
                state <= cmd[acs_pkg::CTRL_STOP] ? ACM_LOW : ACM_DONE;
                phase <= 2'd2;
                bitn  <= 4'h0;
              end else begin
                state <= ACM_LOW;
              end
            end else if (phase == 2'd0) begin
              phase <= (cmd[acs_pkg::CTRL_WRITE] | cmd[acs_pkg::CTRL_READ]) ? 2'd1 : 2'd2;
              state <= (cmd[acs_pkg::CTRL_WRITE] | cmd[acs_pkg::CTRL_READ] |
                        cmd[acs_pkg::CTRL_STOP]) ? ACM_LOW : ACM_DONE;
            end else begin
              state <= ACM_DONE;
            end
          end
        end
        ACM_DONE: begin
          busy  <= 1'b0;
          state <= ACM_IDLE;
        end
        default: state <= ACM_IDLE;
      endcase
    end
  end
endmodule // acs_master

/* dv/acs_link_asserts.sv */
`timescale 1ns/1ps
module acs_link_asserts (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_s_o,
  input  wire logic sda_s_oe
);
  // ****************************************
  // Helper state
  // ****************************************
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic       hi_seen;
  logic [5:0] rises;
  wire        start_ev = scl & scl_q & sda_q & ~sda;
  wire        stop_ev  = scl & scl_q & ~sda_q & sda;
  // Line levels one cycle back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Frame open between start and stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      in_frame <= 1'h0;
    else if (start_ev)
      in_frame <= 1'h1;
    else if (stop_ev)
      in_frame <= 1'h0;
  end
  // Clock rises since last start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rises <= 6'h00;
    else if (start_ev)
      rises <= 6'h00;
    else if (scl & ~scl_q)
      rises <= rises + 6'h01;
  end
  // Clock high seen while slave drives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hi_seen <= 1'h0;
    else if (!sda_s_oe)
      hi_seen <= 1'h0;
    else if (scl)
      hi_seen <= 1'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Properties
  // ****************************************
  property p_slave_stable;
    scl && scl_q |-> $stable(sda_s_oe);
  endproperty
  a_slave_stable: assert property (p_slave_stable)
    else $error("slave data moved while clock high");
  property p_ack_place;
    $rose(sda_s_oe) |-> !scl && (rises % 6'h09) == 6'h08;
  endproperty
  a_ack_place: assert property (p_ack_place)
    else $error("slave drove outside ninth bit slot");
  property p_ack_low;
    sda_s_oe |-> !sda_s_o && !sda;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("slave drive did not hold line low");
  property p_ack_full;
    $fell(sda_s_oe) |-> !scl && hi_seen;
  endproperty
  a_ack_full: assert property (p_ack_full)
    else $error("slave released before full high period");
  property p_ack_span;
    $rose(sda_s_oe) |-> ##[50:1000] $fell(sda_s_oe);
  endproperty
  a_ack_span: assert property (p_ack_span)
    else $error("slave low not one clock cycle");
  property p_frame_only;
    sda_s_oe |-> in_frame;
  endproperty
  a_frame_only: assert property (p_frame_only)
    else $error("slave drove while bus idle");
  property p_start_hold;
    start_ev |=> scl [*4] ##[1:300] !scl;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("clock not held then lowered after start");
  property p_stop_free;
    stop_ev |-> !sda_s_oe ##1 (scl && sda) [*3];
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("bus not released after stop");
endmodule // acs_link_asserts

/* dv/adc_two_wire_slave_config_test.sv */
`timescale 1ns/1ps
module adc_two_wire_slave_config_test;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        hclk      = 1'h0;
  logic        hresetn   = 1'h0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [7:0]  setup_byte, config_byte, out_code;
  logic        hs_mode, ext_clock, single_ended, read_req, bipolar;
  logic [2:0]  ref_select;
  logic [3:0]  chan_sel;
  logic [1:0]  scan_sel;
  logic [8:0]  diff_code = 9'h0;
  logic [8:0]  shreg     = 9'h0;
  int          errors, n_checks, cycles, k, j;
  int          seed      = 11;
  int          sm, cm, hm, rd;
  logic [31:0] rv;
  acs_link_if lnk ();
  acs_master i_acs_master (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link(lnk.master));
  acs_slave i_acs_slave (.hclk(hclk), .hresetn(hresetn), .link(lnk.device),
    .setup_byte(setup_byte), .config_byte(config_byte), .hs_mode(hs_mode),
    .ext_clock(ext_clock), .ref_select(ref_select), .single_ended(single_ended),
    .bipolar(bipolar), .chan_sel(chan_sel), .scan_sel(scan_sel), .read_req(read_req),
    .diff_code(diff_code), .out_code(out_code));
  acs_link_asserts i_asserts (.hclk(hclk), .hresetn(hresetn), .scl(lnk.scl),
    .sda(lnk.sda), .sda_s_o(lnk.sda_s_o), .sda_s_oe(lnk.sda_s_oe));
  // Clock, timeout and wire capture
  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      final_report();
    end
  end
  always @(posedge lnk.scl) begin
    shreg <= {shreg[7:0], lnk.sda};
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    r = hrdata;
  endtask
  // Link command: 01 start, 02 stop, 04 send byte
  task automatic cmd(input logic [4:0] c, input logic [7:0] b, input int en);
    logic [31:0] r;
    if (c[2])
      ahb(1'h1, acs_pkg::OFF_DATA, {24'h0, b}, r);
    ahb(1'h1, acs_pkg::OFF_CTRL, {27'h0, c}, r);
    repeat (3) @(posedge hclk);
    r = 32'h1;
    while (r[acs_pkg::STAT_BUSY] !== 1'h0)
      ahb(1'h0, acs_pkg::OFF_STAT, 32'h0, r);
    if (en >= 0)
      check("nack", r[acs_pkg::STAT_NACK], en[0]);
  endtask
  task automatic xfer(input logic [7:0] adr, input int en);
    cmd(5'h01, 8'h00, -1);
    cmd(5'h04, adr, en);
    check("wire", shreg, {adr, en[0]});
  endtask
  // Byte write and model update
  task automatic wbyte(input logic [7:0] b);
    cmd(5'h04, b, 0);
    if (!b[7])
      cm = b;
    else begin
      sm = b;
      if (!b[1])
        cm = acs_pkg::CONFIG_RESET;
    end
  endtask
  task automatic cmp_state();
    logic [8:0] d;
    logic [7:0] e;
    repeat (8) @(posedge hclk);
    check("setup", setup_byte[7:1], sm[7:1]);
    check("config", config_byte, cm[7:0]);
    check("refsel", ref_select, sm[6:4]);
    check("clksrc", ext_clock, sm[3]);
    check("pairing", single_ended, cm[0]);
    check("chan", chan_sel, cm[4:1]);
    check("scan", scan_sel, cm[6:5]);
    check("hs", hs_mode, hm[0]);
    check("rdreq", read_req, rd[0]);
    check("bipolar", bipolar, sm[2] && !cm[0]);
    for (int i = 0; i < 3; i++) begin
      d = 9'($random(seed));
      diff_code <= d;
      repeat (3) @(posedge hclk);
      e = (sm[2] && !cm[0]) ? d[8:1] : (d[8] ? 8'h00 : d[7:0]);
      check("code", out_code, e);
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sm = acs_pkg::SETUP_RESET;
    cm = acs_pkg::CONFIG_RESET;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    cmp_state();
    // Writes of one or two bytes in both orders
    for (k = 0; k < 10; k++) begin
      xfer({acs_pkg::DEV_ADDR, 1'h0}, 0);
      rd = 0;
      for (j = 0; j <= k % 2; j++)
        wbyte({k[1] ^ j[0], 7'($random(seed))});
      cmd(5'h02, 8'h00, -1);
      check("idle", {lnk.scl, lnk.sda}, 2'h3);
      cmp_state();
    end
    // Foreign address ignored
    xfer({acs_pkg::DEV_ADDR ^ 7'h01, 1'h0}, 1);
    cmd(5'h02, 8'h00, -1);
    cmp_state();
    // Read direction
    xfer({acs_pkg::DEV_ADDR, 1'h1}, 0);
    rd = 1;
    // Master reads one byte, refuses it, then stops
    cmd(5'h0A, 8'h00, 1);
    ahb(1'h0, acs_pkg::OFF_DATA, 32'h0, rv);
    check("rxbyte", rv, 32'h0000_00FF);
    cmp_state();
    // High-speed entry, repeated start, stop
    cmd(5'h01, 8'h00, -1);
    cmd(5'h04, {5'h01, 3'($random(seed))}, 1);
    cmp_state();
    // Mode switches once the not-acknowledge slot closes
    xfer({acs_pkg::DEV_ADDR, 1'h0}, 0);
    rd = 0;
    hm = 1;
    cmp_state();
    wbyte(8'($random(seed)));
    cmd(5'h02, 8'h00, -1);
    hm = 0;
    cmp_state();
    final_report();
  end
endmodule // adc_two_wire_slave_config_test
